// File: adc_readout_defines.vh
// Constants for the dual-channel converter readout block
// Assumes inclusion by bare name from the design files
`ifndef ADC_READOUT_DEFINES_VH
`define ADC_READOUT_DEFINES_VH
`define RESULT_BITS 16
`define CLK_PERIOD_NS 10
`define CNV_MIN_WIDTH_NS 25
`define CNV_MIN_WIDTH_CYC ((`CNV_MIN_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS 300
// Conversion time in system clocks, sized for the conversion timer
`define CONV_TIME_CYC 9'h01e
`define FIFO_DEPTH 8
`define ST_OPER 2'h0
`define ST_NAP 2'h1
`define ST_SLEEP 2'h2
`define PULSES_TO_NAP 3'h2
`define PULSES_TO_SLEEP 3'h4
`define PULSES_TO_WAKE 3'h5
`endif

// File: result_fifo.v
// Small synchronous FIFO holding conversion result pairs
// Assumes one clock and an active-high asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Write side
  input wire i_wr_valid,
  output wire o_wr_ready,
  input wire [WIDTH-1:0] i_wr_data,
  // Read side
  output wire o_rd_valid,
  input wire i_rd_ready,
  output reg [WIDTH-1:0] o_rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg out_full;
  wire wr_fire;
  wire pop_mem;
  assign o_wr_ready = (count != DEPTH[AW:0]);
  assign wr_fire = i_wr_valid && o_wr_ready;
  assign o_rd_valid = out_full;
  assign pop_mem = (count != {(AW+1){1'b0}}) && (!out_full || i_rd_ready);
  always @(posedge i_clk) begin
    if (wr_fire) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      o_rd_data <= {WIDTH{1'b0}};
    end else begin
      if (wr_fire) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop_mem) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        o_rd_data <= mem[rd_ptr];
        out_full <= 1'b1;
      end else if (i_rd_ready) begin
        out_full <= 1'b0;
      end
      case ({wr_fire, pop_mem})
        2'b10: count <= count + {{AW{1'b0}}, 1'b1};
        2'b01: count <= count - {{AW{1'b0}}, 1'b1};
        default: count <= count;
      endcase
    end
  end
endmodule // result_fifo
`default_nettype wire

// File: adc_readout.v
// Conversion control, power states and serial readout of a dual converter
// Assumes strobe, shift clock and straps arrive asynchronously to i_mclk
// Operation
// - Strobe rising edge puts both sample-and-holds into tracking
// - Strobe falling edge holds the samples and, while operational, starts conversion
// - Each shift-clock falling edge presents next result bit, MSB first
// - Echo clock is driven with the same timing as the data lanes
// - Negative echo pin strapped high disables the positive echo output
// - With shift clock idle, second strobe rising edge enters nap
// - Nap lasts until shift-clock rising edge wakes, or more strobes
// - Two further idle strobes in nap enter sleep
// - In CMOS mode a shift-clock rising edge wakes from sleep
// - In LVDS mode the fifth idle strobe wakes from sleep
// - Shift-clock pulses between strobes stop counting toward nap or sleep
// - Fifth-strobe wake from sleep also works in CMOS mode
// - Idle strobes cycle operational, nap, sleep repeatedly in order
// - Supply-monitor reset reinitialises the converter
// - Interface-select pin chooses CMOS or LVDS signalling
`timescale 1ns/1ns
`default_nettype none
`include "adc_readout_defines.vh"
module adc_readout #(
  parameter RESULT_BITS = `RESULT_BITS,
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = 3
) (
  // Clock and supply-monitor reset
  input wire i_mclk,
  input wire i_rst,
  // Pins from the controller
  input wire i_conversion_strobe,
  input wire i_shift_clock,
  input wire i_lvds_select,
  input wire i_echo_neg_strap,
  // Results of the analog core
  input wire [RESULT_BITS-1:0] i_channel1_sample,
  input wire [RESULT_BITS-1:0] i_channel2_sample,
  // Serial outputs
  output reg o_channel1_data_out,
  output reg o_channel2_data_out,
  output reg o_echo_clock_out,
  output reg o_echo_clock_en,
  // Analog core control and state
  output reg o_track,
  output reg o_converting,
  output reg [1:0] o_power_state,
  output reg o_lvds_mode,
  output wire o_fifo_overflow_stall
);
  // Synchronised pins and their edge history
  reg [1:0] cnv_sync;
  reg [1:0] sck_sync;
  reg [1:0] lvds_sync;
  reg [1:0] strap_sync;
  reg cnv_prev;
  reg sck_prev;
  wire cnv_rise;
  wire cnv_fall;
  wire sck_rise;
  wire sck_fall;
  // Power state
  reg [2:0] pulse_count;
  reg sck_seen;
  reg [1:0] next_power_state;
  reg [2:0] next_pulse_count;
  reg [2:0] counted;
  // Conversion
  reg [8:0] conv_timer;
  reg [2*RESULT_BITS-1:0] sample_hold;
  wire conv_done;
  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire [2*RESULT_BITS-1:0] fifo_rd_data;
  reg fifo_rd_ready;
  reg fifo_wr_valid;
  // Shifter
  reg [RESULT_BITS-1:0] shift1;
  reg [RESULT_BITS-1:0] shift2;
  reg [4:0] bits_left;
  wire shift_load;
  wire shift_step;

  // Edge of a synchronised level against its previous sample
  function rise_of(input now_level, input prev_level);
    begin
      rise_of = now_level && !prev_level;
    end
  endfunction

  function fall_of(input now_level, input prev_level);
    begin
      fall_of = !now_level && prev_level;
    end
  endfunction

  // Strobe count after one more idle strobe; clock activity restarts it
  function [2:0] count_after(input [2:0] count, input clock_seen);
    begin
      if (clock_seen) begin
        count_after = 3'h1;
      end else begin
        count_after = count + 3'h1;
      end
    end
  endfunction

  // Two-flop synchronisers, one per pin
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnv_sync <= 2'h0;
    end else begin
      cnv_sync <= {cnv_sync[0], i_conversion_strobe};
    end
  end
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sck_sync <= 2'h0;
    end else begin
      sck_sync <= {sck_sync[0], i_shift_clock};
    end
  end
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lvds_sync <= 2'h0;
    end else begin
      lvds_sync <= {lvds_sync[0], i_lvds_select};
    end
  end
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      strap_sync <= 2'h0;
    end else begin
      strap_sync <= {strap_sync[0], i_echo_neg_strap};
    end
  end

  // Previous samples, reset to the idle level of both pins
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnv_prev <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      cnv_prev <= cnv_sync[1];
      sck_prev <= sck_sync[1];
    end
  end
  assign cnv_rise = rise_of(cnv_sync[1], cnv_prev);
  assign cnv_fall = fall_of(cnv_sync[1], cnv_prev);
  assign sck_rise = rise_of(sck_sync[1], sck_prev);
  assign sck_fall = fall_of(sck_sync[1], sck_prev);

  // Interface mode and echo enable from straps
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_lvds_mode <= 1'b0;
    end else begin
      o_lvds_mode <= lvds_sync[1];
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_echo_clock_en <= 1'b1;
    end else begin
      o_echo_clock_en <= !strap_sync[1];
    end
  end

  // Power state machine
  always @* begin
    next_power_state = o_power_state;
    next_pulse_count = pulse_count;
    counted = count_after(pulse_count, sck_seen);
    if (sck_rise) begin
      next_pulse_count = 3'h0;
      if (o_power_state == `ST_NAP) begin
        next_power_state = `ST_OPER;
      end else if (o_power_state == `ST_SLEEP && !o_lvds_mode) begin
        next_power_state = `ST_OPER;
      end
    end else if (cnv_rise) begin
      next_pulse_count = counted;
      case (counted)
        `PULSES_TO_NAP: next_power_state = `ST_NAP;
        `PULSES_TO_SLEEP: next_power_state = `ST_SLEEP;
        `PULSES_TO_WAKE: begin
          next_power_state = `ST_OPER;
          next_pulse_count = 3'h0;
        end
        default: next_power_state = o_power_state;
      endcase
    end
  end

  // Power state and strobe count registers
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_power_state <= `ST_OPER;
      pulse_count <= 3'h0;
    end else begin
      o_power_state <= next_power_state;
      pulse_count <= next_pulse_count;
    end
  end

  // Clock activity since the last strobe
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sck_seen <= 1'b0;
    end else if (sck_rise || sck_fall) begin
      sck_seen <= 1'b1;
    end else if (cnv_rise) begin
      sck_seen <= 1'b0;
    end
  end

  // Acquisition follows the strobe edges
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_track <= 1'b0;
    end else if (cnv_rise) begin
      o_track <= 1'b1;
    end else if (cnv_fall) begin
      o_track <= 1'b0;
    end
  end

  assign conv_done = o_converting && (conv_timer == 9'h001);

  // Conversion timer, started by a strobe fall while operational
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_converting <= 1'b0;
      conv_timer <= 9'h000;
    end else if (cnv_fall && o_power_state == `ST_OPER) begin
      o_converting <= 1'b1;
      conv_timer <= `CONV_TIME_CYC;
    end else if (o_converting) begin
      if (conv_done) begin
        o_converting <= 1'b0;
      end
      conv_timer <= conv_timer - 9'h001;
    end
  end

  // Result pair captured at the end of conversion and offered to the FIFO
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sample_hold <= {(2*RESULT_BITS){1'b0}};
      fifo_wr_valid <= 1'b0;
    end else if (conv_done) begin
      sample_hold <= {i_channel1_sample, i_channel2_sample};
      fifo_wr_valid <= 1'b1;
    end else if (fifo_wr_ready) begin
      fifo_wr_valid <= 1'b0;
    end
  end

  assign o_fifo_overflow_stall = fifo_wr_valid && !fifo_wr_ready;

  result_fifo #(
    .WIDTH(2*RESULT_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk(i_mclk),
    .i_rst(i_rst),
    .i_wr_valid(fifo_wr_valid),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data(sample_hold),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(fifo_rd_ready),
    .o_rd_data(fifo_rd_data)
  );

  // Serial shifter: load on strobe rise when idle, shift on shift-clock falls
  assign shift_load = cnv_rise && (bits_left == 5'h00) && fifo_rd_valid;
  assign shift_step = sck_fall && (bits_left != 5'h00) && !shift_load;

  always @* begin
    fifo_rd_ready = shift_load;
  end

  // Shift registers of both lanes
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      shift1 <= {RESULT_BITS{1'b0}};
      shift2 <= {RESULT_BITS{1'b0}};
    end else if (shift_load) begin
      shift1 <= fifo_rd_data[2*RESULT_BITS-1:RESULT_BITS];
      shift2 <= fifo_rd_data[RESULT_BITS-1:0];
    end else if (shift_step) begin
      shift1 <= {shift1[RESULT_BITS-2:0], 1'b0};
      shift2 <= {shift2[RESULT_BITS-2:0], 1'b0};
    end
  end

  // Bits still to be shifted out of the loaded word
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bits_left <= 5'h00;
    end else if (shift_load) begin
      bits_left <= RESULT_BITS[4:0];
    end else if (shift_step) begin
      bits_left <= bits_left - 5'h01;
    end
  end

  // Lane outputs, MSB first
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_channel1_data_out <= 1'b0;
    end else if (shift_step) begin
      o_channel1_data_out <= shift1[RESULT_BITS-1];
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_channel2_data_out <= 1'b0;
    end else if (shift_step) begin
      o_channel2_data_out <= shift2[RESULT_BITS-1];
    end
  end

  // Echo follows the sampled shift clock in the same stage as the data
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_echo_clock_out <= 1'b0;
    end else begin
      o_echo_clock_out <= !strap_sync[1] && sck_sync[1];
    end
  end
endmodule // adc_readout
`default_nettype wire

// File: adc_readout_props.sv
// Port checker for the converter readout block
// Assumes pins reach the core through 2-flop syncs
`timescale 1ns/1ns
`default_nettype none
`include "adc_readout_defines.vh"
module adc_readout_props (
  // Clock, reset and pins
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_conversion_strobe,
  input wire logic i_shift_clock,
  input wire logic i_lvds_select,
  input wire logic i_echo_neg_strap,
  // Outputs watched
  input wire logic o_echo_clock_out,
  input wire logic o_echo_clock_en,
  input wire logic o_track,
  input wire logic o_converting,
  input wire logic [1:0] o_power_state,
  input wire logic o_lvds_mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence sck_rise;
    $rose(i_shift_clock);
  endsequence
  sequence nap_sck;
    o_power_state == `ST_NAP ##0 sck_rise;
  endsequence
  sequence sleep_sck;
    o_power_state == `ST_SLEEP && !o_lvds_mode ##0 sck_rise;
  endsequence
  a_track_on_rise: assert property ($rose(i_conversion_strobe) && o_power_state == `ST_OPER
    |-> ##[2:6] (o_track || o_power_state != `ST_OPER)) else $error("track late");
  a_hold_on_fall: assert property ($fell(i_conversion_strobe) |-> ##[2:6] !o_track) else $error("hold late");
  a_conv_starts: assert property ($fell(o_track) && o_power_state == `ST_OPER
    |-> ##[0:3] o_converting) else $error("no conversion");
  a_conv_lasts: assert property ($rose(o_converting) |-> o_converting[*8]) else $error("conversion short");
  a_idle_no_conv: assert property (o_power_state != `ST_OPER |-> !$rose(o_converting)) else $error("converting");
  a_nap_wake: assert property (nap_sck |-> ##[2:6] o_power_state == `ST_OPER) else $error("nap wake");
  a_sleep_wake: assert property (sleep_sck |-> ##[2:6] o_power_state == `ST_OPER) else $error("sleep wake");
  a_echo_strap: assert property ($stable(i_echo_neg_strap)[*5]
    |-> o_echo_clock_en == !i_echo_neg_strap) else $error("echo enable");
  a_echo_gated: assert property (!o_echo_clock_en |-> !o_echo_clock_out) else $error("echo active");
  a_mode_select: assert property ($stable(i_lvds_select)[*5] |-> o_lvds_mode == i_lvds_select)
    else $error("mode select");
  a_reset_oper: assert property ($fell(i_rst) |-> o_power_state == `ST_OPER && !o_converting)
    else $error("reset state");
endmodule // adc_readout_props
bind adc_readout adc_readout_props adc_readout_props_i (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_conversion_strobe(i_conversion_strobe), .i_shift_clock(i_shift_clock), .i_lvds_select(i_lvds_select),
  .i_echo_neg_strap(i_echo_neg_strap), .o_echo_clock_out(o_echo_clock_out), .o_echo_clock_en(o_echo_clock_en),
  .o_track(o_track), .o_converting(o_converting), .o_power_state(o_power_state), .o_lvds_mode(o_lvds_mode));
`default_nettype wire

// File: adc_controller_model.sv
// Controller model driving strobe and shift clock
// Assumes i_mclk is the bench clock; shift clock period 125 ns
`timescale 1ns/1ns
`default_nettype none
module adc_controller_model (
  // Bench clock
  input wire logic i_mclk,
  // Lanes and echo from the converter
  input wire logic i_lane1,
  input wire logic i_lane2,
  input wire logic i_echo,
  // Pins to the converter
  output logic o_strobe,
  output logic o_sck
);
  initial begin
    o_strobe = 1'b0;
    o_sck = 1'b0;
  end
  // Strobe 50 ns wide, shift clock static, then rest
  task automatic pulse;
    @(posedge i_mclk);
    o_strobe <= 1'b1;
    repeat (5) @(posedge i_mclk);
    o_strobe <= 1'b0;
    repeat (45) @(posedge i_mclk);
  endtask
  // One shift clock pulse, then the clock stands low
  task automatic wake;
    #63 o_sck = 1'b1;
    #62 o_sck = 1'b0;
    #63;
  endtask
  // Sixteen shift clock pulses capturing both lanes and the echo
  task automatic frame(output logic [15:0] d1, output logic [15:0] d2, output logic [15:0] ek);
    for (int i = 15; i >= 0; i--) begin
      o_sck = 1'b1;
      #50 ek[i] = i_echo;
      #12 o_sck = 1'b0;
      #50 d1[i] = i_lane1;
      d2[i] = i_lane2;
      #13;
    end
  endtask
endmodule // adc_controller_model
`default_nettype wire

// File: test_adc_readout.sv
// Self-checking bench for the converter readout block
// Assumes the controller model drives strobe and shift clock
`timescale 1ns/1ns
`default_nettype none
`include "adc_readout_defines.vh"
module test_adc_readout;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic lvds = 1'b0;
  logic strap = 1'b0;
  logic [15:0] s1 = 16'h0000;
  logic [15:0] s2 = 16'h0000;
  wire strobe, sck, d1, d2, ek, trk, conv, lvm;
  wire [1:0] st;
  int error_cnt = 0;
  int checks = 0;
  // Scaled-down settling wait standing for the long reference recovery
  localparam int SETTLE_CYC = 20;
  always #5 i_mclk = ~i_mclk;
  adc_readout adc_readout_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_conversion_strobe(strobe), .i_shift_clock(sck),
    .i_lvds_select(lvds), .i_echo_neg_strap(strap), .i_channel1_sample(s1), .i_channel2_sample(s2),
    .o_channel1_data_out(d1), .o_channel2_data_out(d2), .o_echo_clock_out(ek), .o_echo_clock_en(),
    .o_track(trk), .o_converting(conv), .o_power_state(st), .o_lvds_mode(lvm), .o_fifo_overflow_stall());
  adc_controller_model adc_controller_model_i (.i_mclk(i_mclk), .i_lane1(d1), .i_lane2(d2), .i_echo(ek),
    .o_strobe(strobe), .o_sck(sck));
  task automatic chk_state(string what, logic [1:0] exp);
    checks++;
    if (st !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, st);
    end
  endtask
  task automatic chk_word(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Readout of the previous conversion, then echo strapped off
  task automatic t_read;
    logic [15:0] r1, r2, e;
    s1 <= 16'ha5c3;
    s2 <= 16'h3c5a;
    adc_controller_model_i.pulse();
    adc_controller_model_i.wake();
    @(posedge i_mclk);
    s1 <= 16'h0ff0;
    s2 <= 16'hf00f;
    adc_controller_model_i.pulse();
    adc_controller_model_i.frame(r1, r2, e);
    chk_word("lane one", 16'ha5c3, r1);
    chk_word("lane two", 16'h3c5a, r2);
    chk_word("echo on", 16'hffff, e);
    @(posedge i_mclk);
    strap <= 1'b1;
    repeat (8) @(posedge i_mclk);
    adc_controller_model_i.frame(r1, r2, e);
    chk_word("echo off", 16'h0000, e);
    strap <= 1'b0;
    $display("read test done");
  endtask
  // Idle strobes walk the power states, then one clock edge wakes nap
  task automatic t_cycle(logic mode);
    logic [1:0] exp [7] = '{`ST_OPER, `ST_NAP, `ST_NAP, `ST_SLEEP, `ST_OPER, `ST_OPER, `ST_NAP};
    @(posedge i_mclk);
    lvds <= mode;
    for (int i = 0; i < 7; i++) begin
      adc_controller_model_i.pulse();
      chk_state("power state", exp[i]);
    end
    adc_controller_model_i.wake();
    chk_state("nap wake", `ST_OPER);
    $display("cycle test done");
  endtask
  // Clock edge wakes sleep in CMOS; clock between strobes stops counting
  task automatic t_sleep_sck;
    @(posedge i_mclk);
    lvds <= 1'b0;
    repeat (4) adc_controller_model_i.pulse();
    chk_state("asleep", `ST_SLEEP);
    adc_controller_model_i.wake();
    chk_state("sleep wake", `ST_OPER);
    repeat (SETTLE_CYC) @(posedge i_mclk);
    repeat (3) begin
      adc_controller_model_i.pulse();
      adc_controller_model_i.wake();
    end
    chk_state("busy clock", `ST_OPER);
    $display("sleep test done");
  endtask
  // Reset in nap returns to operation with the count cleared
  task automatic t_reset;
    repeat (2) adc_controller_model_i.pulse();
    chk_state("nap first", `ST_NAP);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    chk_state("after reset", `ST_OPER);
    repeat (SETTLE_CYC) @(posedge i_mclk);
    adc_controller_model_i.pulse();
    chk_state("count cleared", `ST_OPER);
    $display("reset test done");
  endtask
  initial begin
    #200000;
    error_cnt++;
    $display("ERROR watchdog expected finish seen hang");
    conclude();
  end
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    chk_state("reset state", `ST_OPER);
    t_read();
    t_cycle(1'b0);
    t_cycle(1'b1);
    t_sleep_sck();
    t_reset();
    conclude();
  end
endmodule // test_adc_readout
`default_nettype wire
